// ---- verilog/hdlc_tx_defines.svh ----
`ifndef HDLC_TX_DEFINES_SVH
`define HDLC_TX_DEFINES_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_CHAN_MODE 12'h000
`define ADDR_TX_STATE 12'h004
`define ADDR_TX_CTRL 12'h008
`define ADDR_TX_STATUS 12'h00c
// ----------------------------------------
// channel mode fields (msb-first bit n sits at 15-n)
// ----------------------------------------
`define MODE_HDLC_BIT 15
`define MODE_IDLE_BIT 13
`define MODE_POLL_BIT 8
`define MODE_CRC_BIT 7
`define MODE_NOF_MSB 3
`define MODE_NOF_LSB 0
`define CHAN_MODE_WMASK 16'ha18f
`define CHAN_MODE_RST 16'h0000
// ----------------------------------------
// tx state word high byte (byte bit n sits at 31-n)
// ----------------------------------------
`define TST_ORDER_BIT 28
`define TST_FC_MSB 27
`define TST_FC_LSB 24
`define TST_AT_MSB 26
`define TST_AT_LSB 24
`define TX_STATE_RST 32'h0000_0000
// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_EN_BIT 0
`define CTRL_ATV_BIT 1
// ----------------------------------------
// timing: clock cycles per flag on the line
// ----------------------------------------
`define FLAG_CYCLES 8'h08
`endif

// ---- verilog/hdlc_tx_pkg.sv ----
package hdlc_tx_pkg;
  typedef enum {st_idle, st_poll, st_flags, st_frame} tx_fsm_type;
  // qualifiers driven with every transmit-buffer dma cycle
  typedef struct packed {
    logic big_endian;
    logic at_variant;
    logic [3:0] func_code;
    logic [2:0] addr_type;
  } dma_attr_type;
  // framing options for the serial datapath
  typedef struct packed {
    logic hdlc_mode;
    logic crc32_select;
    logic idle_pattern_enable;
  } frame_cfg_type;
endpackage

// ---- verilog/flag_tick_divider.sv ----
`timescale 1ns/10ps
`include "hdlc_tx_defines.svh"
module flag_tick_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic tick
);
  logic [7:0] count;
  logic [7:0] next_count;

  // ----------------------------------------
  // down counter, restarts whenever run drops
  // ----------------------------------------
  always_comb begin
    next_count = count;
    if (!run || count == 8'h00) begin
      next_count = `FLAG_CYCLES - 8'h01;
    end else begin
      next_count = count - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= `FLAG_CYCLES - 8'h01;
    end else begin
      count <= next_count;
    end
  end

  // one-cycle enable at the end of each flag period
  assign tick = run && (count == 8'h00);
endmodule // flag_tick_divider

// ---- verilog/hdlc_channel_tx_config.sv ----
`timescale 1ns/10ps
`include "hdlc_tx_defines.svh"
// Summary of operation
// - poll bit set: read descriptor ready flag; clear: no polling cycles
// - device clears poll bit on finding a descriptor not ready
// - crc select one in hdlc mode picks 32-bit crc
// - four-bit flag count sets minimum flags before each frame
// - at least one flag before first frame even with count zero
// - byte-order bit: 0 little-endian, 1 big-endian dma
// - function-code variant drives bits 4-7 on dma cycles
// - address-type variant: bit 4 zero, bits 5-7 driven as type
// - mode bit: 0 transparent, 1 hdlc framing with flags and crc
// - without idle mode, send flag count plus one flags per frame
module hdlc_channel_tx_config
  import hdlc_tx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic desc_poll_req,
  input wire logic desc_poll_ack,
  input wire logic desc_ready,
  output logic flag_active,
  output logic frame_go,
  input wire logic frame_end,
  output frame_cfg_type frame_cfg,
  output dma_attr_type dma_attr
);
  logic [15:0] chan_mode;
  logic [15:0] next_chan_mode;
  logic [31:0] tx_state;
  logic [31:0] next_tx_state;
  logic tx_en;
  logic next_tx_en;
  logic at_variant;
  logic next_at_variant;
  logic [31:0] next_prdata;
  tx_fsm_type state;
  tx_fsm_type next_state;
  logic [3:0] flags_left;
  logic [3:0] next_flags_left;
  logic flag_tick;
  logic poll_clear;
  logic wr_access;
  logic rd_setup;
  logic mapped;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign wr_access = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped = (paddr == `ADDR_CHAN_MODE) || (paddr == `ADDR_TX_STATE)
    || (paddr == `ADDR_TX_CTRL) || (paddr == `ADDR_TX_STATUS);
  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always_comb begin
    next_chan_mode = chan_mode;
    next_tx_state = tx_state;
    next_tx_en = tx_en;
    next_at_variant = at_variant;
    if (poll_clear) begin
      next_chan_mode[`MODE_POLL_BIT] = 1'b0;
    end
    if (wr_access && paddr == `ADDR_CHAN_MODE) begin
      // poll bit can only be set by software; a set beats a clear
      next_chan_mode = (pwdata[15:0] & `CHAN_MODE_WMASK)
        & ~(16'h0001 << `MODE_POLL_BIT);
      next_chan_mode[`MODE_POLL_BIT] = pwdata[`MODE_POLL_BIT]
        || (chan_mode[`MODE_POLL_BIT] && !poll_clear);
    end
    // working state must not be disturbed while transmitting
    if (wr_access && paddr == `ADDR_TX_STATE && !tx_en) begin
      next_tx_state = pwdata;
    end
    if (wr_access && paddr == `ADDR_TX_CTRL) begin
      next_tx_en = pwdata[`CTRL_EN_BIT];
      next_at_variant = pwdata[`CTRL_ATV_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_mode <= `CHAN_MODE_RST;
      tx_state <= `TX_STATE_RST;
      tx_en <= 1'b0;
      at_variant <= 1'b0;
    end else begin
      chan_mode <= next_chan_mode;
      tx_state <= next_tx_state;
      tx_en <= next_tx_en;
      at_variant <= next_at_variant;
    end
  end

  // ----------------------------------------
  // read data, registered in the setup cycle
  // ----------------------------------------
  always_comb begin
    next_prdata = prdata;
    if (rd_setup) begin
      unique case (paddr)
        `ADDR_CHAN_MODE: next_prdata = {16'h0000, chan_mode};
        `ADDR_TX_STATE: next_prdata = tx_state;
        `ADDR_TX_CTRL: next_prdata = {30'h0000_0000, at_variant, tx_en};
        `ADDR_TX_STATUS: next_prdata = {25'h000_0000, frame_go,
          flag_active, desc_poll_req, flags_left};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------
  // configuration outputs straight from registers
  // ----------------------------------------
  // crc choice only matters when hdlc framing is selected
  assign frame_cfg.hdlc_mode = chan_mode[`MODE_HDLC_BIT];
  assign frame_cfg.crc32_select = chan_mode[`MODE_HDLC_BIT]
    && chan_mode[`MODE_CRC_BIT];
  assign frame_cfg.idle_pattern_enable = chan_mode[`MODE_IDLE_BIT];
  assign dma_attr.big_endian = tx_state[`TST_ORDER_BIT];
  assign dma_attr.at_variant = at_variant;
  assign dma_attr.func_code = tx_state[`TST_FC_MSB:`TST_FC_LSB];
  assign dma_attr.addr_type = tx_state[`TST_AT_MSB:`TST_AT_LSB];

  // ----------------------------------------
  // descriptor polling and opening flags
  // ----------------------------------------
  flag_tick_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(flag_active),
    .tick(flag_tick)
  );

  assign desc_poll_req = (state == st_poll);
  assign flag_active = (state == st_flags);
  assign frame_go = (state == st_frame);
  assign poll_clear = desc_poll_req && desc_poll_ack && !desc_ready;

  always_comb begin
    next_state = state;
    next_flags_left = flags_left;
    unique case (state)
      st_idle: begin
        if (tx_en && chan_mode[`MODE_POLL_BIT]) begin
          next_state = st_poll;
        end
      end
      st_poll: begin
        if (!tx_en) begin
          next_state = st_idle;
        end else if (desc_poll_ack) begin
          // count plus one flags, so a zero count still gives one
          next_flags_left = chan_mode[`MODE_NOF_MSB:`MODE_NOF_LSB];
          next_state = desc_ready ? st_flags : st_idle;
        end
      end
      st_flags: begin
        if (flag_tick) begin
          if (flags_left == 4'h0) begin
            next_state = st_frame;
          end else begin
            next_flags_left = flags_left - 4'h1;
          end
        end
      end
      st_frame: begin
        if (frame_end) begin
          next_state = chan_mode[`MODE_POLL_BIT] ? st_poll : st_idle;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_idle;
      flags_left <= 4'h0;
    end else begin
      state <= next_state;
      flags_left <= next_flags_left;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [4:0] flags_seen;
  logic [3:0] nof_taken;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_seen <= 5'h00;
      nof_taken <= 4'h0;
    end else if (desc_poll_req && desc_poll_ack) begin
      flags_seen <= 5'h00;
      nof_taken <= chan_mode[`MODE_NOF_MSB:`MODE_NOF_LSB];
    end else if (flag_tick) begin
      flags_seen <= flags_seen + 5'h01;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_poll_gate: assert property (
    desc_poll_req |-> chan_mode[`MODE_POLL_BIT])
    else $error("descriptor poll while poll bit clear");
  a_poll_clear: assert property (
    poll_clear && !(wr_access && paddr == `ADDR_CHAN_MODE)
    |=> !chan_mode[`MODE_POLL_BIT] && state == st_idle)
    else $error("poll bit not cleared on empty descriptor");
  a_crc_write: assert property (
    wr_access && paddr == `ADDR_CHAN_MODE
    |=> frame_cfg.crc32_select == ($past(pwdata[`MODE_CRC_BIT])
    && $past(pwdata[`MODE_HDLC_BIT])))
    else $error("crc select does not follow mode write");
  a_flag_count: assert property (
    flag_active && next_state == st_frame
    |=> flags_seen == {1'b0, nof_taken} + 5'h01)
    else $error("wrong number of opening flags");
  a_one_flag: assert property (
    $rose(frame_go) |-> flags_seen >= 5'h01)
    else $error("frame started with no flag");
  a_flag_hold: assert property (
    $rose(flag_active) |-> flag_active [*8])
    else $error("flag shorter than one flag period");
  a_order_write: assert property (
    wr_access && paddr == `ADDR_TX_STATE && !tx_en
    |=> dma_attr.big_endian == $past(pwdata[`TST_ORDER_BIT])
    && dma_attr.func_code == $past(pwdata[`TST_FC_MSB:`TST_FC_LSB]))
    else $error("dma qualifiers do not follow state write");
  a_addr_type: assert property (
    wr_access && paddr == `ADDR_TX_STATE && !tx_en
    |=> dma_attr.addr_type == $past(pwdata[`TST_AT_MSB:`TST_AT_LSB]))
    else $error("address type does not follow state write");
  a_state_guard: assert property (
    wr_access && paddr == `ADDR_TX_STATE && tx_en
    |=> tx_state == $past(tx_state))
    else $error("state word written while enabled");
  a_mode_write: assert property (
    wr_access && paddr == `ADDR_CHAN_MODE
    |=> frame_cfg.hdlc_mode == $past(pwdata[`MODE_HDLC_BIT]))
    else $error("framing mode does not follow mode write");

  c_frame_sent: cover property ($fell(frame_go) ##[1:20] desc_poll_req);
  c_empty_desc: cover property (poll_clear);
  c_zero_nof: cover property ($rose(frame_go) && flags_seen == 5'h01);
endmodule // hdlc_channel_tx_config

// ---- testbench/desc_mem_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// descriptor memory and serial datapath stand-in
// ----------------------------------------
module desc_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic desc_poll_req,
  input wire logic frame_go,
  input wire logic [3:0] lat,
  input wire logic [3:0] queued,
  input wire logic load,
  output logic desc_poll_ack,
  output logic desc_ready,
  output logic frame_end
);
  logic [3:0] pend, wcnt, fcnt;
  logic rdy_q;
  // a released ready line must not keep its old value, so invert it
  assign desc_ready = desc_poll_ack ? rdy_q : ~rdy_q;
  // fetch answered after lat waiting cycles; frame_end is raised after five cycles of frame_go
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pend, wcnt, fcnt, rdy_q, desc_poll_ack, frame_end} <= '0;
    end else begin
      if (load) pend <= queued;
      if (desc_poll_ack) begin
        desc_poll_ack <= 1'b0;
        wcnt <= '0;
      end else if (desc_poll_req && wcnt == lat) begin
        desc_poll_ack <= 1'b1;
        rdy_q <= (pend != 0);
        if (pend != 0) pend <= pend - 4'h1;
      end else if (desc_poll_req) begin
        wcnt <= wcnt + 4'h1;
      end
      if (frame_end) begin
        frame_end <= 1'b0;
        fcnt <= '0;
      end else if (frame_go && fcnt == 4'h4) begin
        frame_end <= 1'b1;
      end else if (frame_go) begin
        fcnt <= fcnt + 4'h1;
      end
    end
  end
endmodule // desc_mem_model

// ---- testbench/test_hdlc_channel_tx_config.sv ----
`timescale 1ns/10ps
`include "hdlc_tx_defines.svh"
module test_hdlc_channel_tx_config;
  import hdlc_tx_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, v;
  logic pready, pslverr, err, req, req_d, ack, rdy, flag_active;
  logic frame_go, fend, at, load = 0;
  logic [3:0] lat = '0, queued = '0, min_flag_count;
  frame_cfg_type frame_cfg;
  dma_attr_type dma_attr;
  int num_errors = 0, checks_done = 0, fcnt = 0, pcnt = 0;
  int seed = 32'h626143d9;
  int flagq[$];
  always #2 pclk = ~pclk;
  hdlc_channel_tx_config dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .desc_poll_req(req), .desc_poll_ack(ack), .desc_ready(rdy),
    .flag_active(flag_active), .frame_go(frame_go), .frame_end(fend),
    .frame_cfg(frame_cfg), .dma_attr(dma_attr));
  desc_mem_model mem (.pclk(pclk), .presetn(presetn), .desc_poll_req(req),
    .frame_go(frame_go), .lat(lat), .queued(queued), .load(load),
    .desc_poll_ack(ack), .desc_ready(rdy), .frame_end(fend));
  // ----------------------------------------
  // monitors: flag burst lengths and fetch starts
  // ----------------------------------------
  always @(posedge pclk) begin
    if (flag_active === 1'b1) fcnt++;
    else if (fcnt != 0) begin
      flagq.push_back(fcnt);
      fcnt = 0;
    end
    if (req === 1'b1 && !req_d) pcnt++;
    req_d = (req === 1'b1);
  end
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer; the request stands until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      report_and_stop();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  initial begin
    int n;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(0, 12'(i * 4), '0);
      chk("reset_value", '0, rd);
      chk("mapped_err", '0, 32'(err));
    end
    apb(0, 12'h010, '0);
    chk("unmapped_err", 32'h1, 32'(err));
    chk("unmapped_rd", '0, rd);
    // random mode words; poll kept clear, software never clears it
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      v[`MODE_POLL_BIT] = 1'b0;
      apb(1, `ADDR_CHAN_MODE, v);
      apb(0, `ADDR_CHAN_MODE, '0);
      chk("mode", v & 32'(`CHAN_MODE_WMASK), rd);
      chk("cfg", 32'({v[15], v[15]&v[7], v[13]}), 32'(frame_cfg));
    end
    // state word: both init values first, then random ones
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 32'h3800_0000 : (i == 1) ? 32'h3000_0000 : $random(seed);
      at = (i == 1) ? 1'b1 : (i == 0) ? 1'b0 : v[0];
      if (i > 1) v[31:29] = 3'b001;
      if (at) v[27] = 1'b0;
      apb(1, `ADDR_TX_CTRL, 32'({at, 1'b0}));
      apb(1, `ADDR_TX_STATE, v);
      apb(0, `ADDR_TX_STATE, '0);
      chk("state", v, rd);
      chk("attr", 32'({v[28], at, v[27:24], v[26:24]}),
        32'(dma_attr));
    end
    apb(1, `ADDR_TX_CTRL, 32'h0);
    apb(1, `ADDR_TX_STATE, 32'h3800_0000);
    // the write lands at the edge the task returns on; look once settled
    @(negedge pclk);
    chk("order", 32'h1, 32'(dma_attr.big_endian));
    apb(1, `ADDR_TX_CTRL, 32'h1);
    apb(1, `ADDR_TX_STATE, 32'h0);
    apb(0, `ADDR_TX_STATE, '0);
    chk("state_locked", 32'h3800_0000, rd);
    apb(1, `ADDR_CHAN_MODE, 32'h8000);
    pcnt = 0;
    repeat (20) @(posedge pclk);
    chk("no_poll", '0, 32'(pcnt));
    // flag count extremes; prompt then slow descriptor answers
    for (int k = 0; k < 2; k++) begin
      min_flag_count = k ? 4'hf : 4'h0;
      lat <= k ? 4'h3 : 4'h0;
      queued <= 4'(k + 1);
      load <= 1'b1;
      @(posedge pclk);
      load <= 1'b0;
      flagq.delete();
      pcnt = 0;
      // hdlc framing and poll bit sit in the low half of the word
      apb(1, `ADDR_CHAN_MODE, {16'h0000, 12'h810, min_flag_count});
      for (n = 0; n < 400; n++) begin
        apb(0, `ADDR_CHAN_MODE, '0);
        if (rd[`MODE_POLL_BIT] === 1'b0) break;
      end
      if (n == 400) begin
        num_errors++;
        report_and_stop();
      end else begin
        chk("poll_cleared", '0, 32'(rd[`MODE_POLL_BIT]));
        chk("fetches", 32'(k + 2), 32'(pcnt));
        chk("frames", 32'(k + 1), 32'(flagq.size()));
        foreach (flagq[j]) begin
          chk("flags", (min_flag_count + 1) * `FLAG_CYCLES, flagq[j]);
        end
      end
    end
    report_and_stop();
  end
endmodule // test_hdlc_channel_tx_config
